// ### rspl_pkg.sv
// shared constants for the reset strap and polarity latch block
package rspl_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================
  localparam logic [7:0] OFF_CTRL = 8'h00; // control: leds, power
  localparam logic [7:0] OFF_STATUS = 8'h04; // read-only state
  localparam logic [7:0] OFF_INT_STATUS = 8'h08; // sticky events, w1c
  localparam logic [7:0] OFF_INT_MASK = 8'h0C; // event enables

  // ==========================================================
  // control register fields
  // ==========================================================
  localparam int CTRL_LED_EN_BIT = 0; // indicator support enabled
  localparam int CTRL_PWR_LSB = 8; // per-port power request
  localparam int CTRL_LED_ON_LSB = 16; // per-port indicator on
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0003_0301;

  // ==========================================================
  // status register fields
  // ==========================================================
  localparam int STAT_CFG_BIT = 0; // latched config select
  localparam int STAT_DRV_LSB = 1; // drive setting in use
  localparam int STAT_POL_BIT = 3; // power polarity in use
  localparam int STAT_LEDPOL_LSB = 4; // indicator polarity
  localparam int STAT_OC_LSB = 8; // live over-current level
  localparam int STAT_DONE_BIT = 15; // straps captured

  // ==========================================================
  // reset values of the latched straps
  // ==========================================================
  localparam logic [1:0] DRV_DEFAULT = 2'h0; // normal drive level
  localparam logic POL_DEFAULT = 1'h1; // active high power enable
  localparam logic CFG_DEFAULT = 1'h0; // straps not honoured
  localparam logic [31:0] INT_RESET = 32'h0000_0000;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int SYNC_STAGES = 2; // flops per pin synchroniser
  localparam int ACK_CYCLES = 1; // bus answer one cycle after request

endpackage : rspl_pkg

// ### rspl_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module rspl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // ==========================================================
  // synchroniser chain
  // ==========================================================
  logic [WIDTH-1:0] meta; // first stage, read only by second

  // no reset: the chain keeps tracking pins while the core is in
  // reset, so strap levels are already settled at the release
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      meta <= pin;
      level <= meta;
    end
  end

endmodule : rspl_sync

// ### rspl_top.sv
// strap capture, port power polarity, indicators, over-current
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rspl_top #(
  parameter int NPORTS = 2, // downstream ports with power control
  parameter bit HAS_POL_STRAP = 1'b1 // polarity pin present
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cfg_select_strap,
  input wire logic [1:0] drive_level_strap,
  input wire logic port_power_polarity_strap,
  input wire logic [NPORTS-1:0] overcurrent_sense_in_n,
  output logic [NPORTS-1:0] port_power_enable_out,
  output logic [1:0] enhanced_port_indicator,
  output logic [1:0] phy_drive_current_setting,
  output logic irq
);

  // ==========================================================
  // helpers
  // ==========================================================
  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] rspl_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : rspl_merge

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  localparam int SW = 4 + NPORTS; // straps plus sense inputs
  logic [SW-1:0] sync_out; // settled pin levels
  logic cfg_s; // config select strap
  logic [1:0] drv_s; // drive level strap
  logic pol_s; // polarity strap
  logic [NPORTS-1:0] oc_now; // over-current, active high

  rspl_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clk_sys(clk_sys),
    .ce(ce),
    .pin({overcurrent_sense_in_n, port_power_polarity_strap,
          drive_level_strap, cfg_select_strap}),
    .level(sync_out)
  );

  assign cfg_s = sync_out[0];
  assign drv_s = sync_out[2:1];
  // absent pin reads as active high
  assign pol_s = HAS_POL_STRAP ? sync_out[3] : rspl_pkg::POL_DEFAULT;
  // inverted active-low sense input is the port's over-current flag
  assign oc_now = ~sync_out[SW-1:4];

  // ==========================================================
  // strap capture at reset release
  // ==========================================================
  logic rst_done; // set at first enabled edge after release
  logic cfg_q; // latched config select
  logic [1:0] drv_q; // latched drive strap
  logic pol_q; // latched power polarity

  // capture happens on a clocked edge after release, since an
  // async reset may only load constants
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_done <= 1'b0;
      cfg_q <= rspl_pkg::CFG_DEFAULT;
      drv_q <= rspl_pkg::DRV_DEFAULT;
      pol_q <= rspl_pkg::POL_DEFAULT;
    end else if (ce && !rst_done) begin
      rst_done <= 1'b1;
      cfg_q <= cfg_s;
      drv_q <= drv_s;
      pol_q <= pol_s;
    end
  end

  // values in use: live strap until capture, latched after
  logic cfg_use; // config select in use
  logic [1:0] drv_use; // drive strap in use
  logic pol_use; // power polarity in use
  logic pol_live; // raw polarity for the reset path
  assign cfg_use = rst_done ? cfg_q : cfg_s;
  assign drv_use = rst_done ? drv_q : drv_s;
  assign pol_use = rst_done ? pol_q : pol_s;
  assign pol_live = HAS_POL_STRAP ? port_power_polarity_strap
                                  : rspl_pkg::POL_DEFAULT;

  // ==========================================================
  // wishbone slave
  // ==========================================================
  logic [31:0] ctrl; // control register
  logic [31:0] int_st; // sticky event bits
  logic [31:0] int_mask; // event enables
  logic req; // request presented
  logic wr_now; // write takes effect this edge
  logic hit_ctrl, hit_stat, hit_ist, hit_imsk; // address decode
  logic [31:0] stat_word; // live status view
  logic [31:0] next_rdata; // selected read word

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_now = req && wb_we_i && wb_ack_o;
  assign hit_ctrl = wb_adr_i[7:2] == rspl_pkg::OFF_CTRL[7:2];
  assign hit_stat = wb_adr_i[7:2] == rspl_pkg::OFF_STATUS[7:2];
  assign hit_ist = wb_adr_i[7:2] == rspl_pkg::OFF_INT_STATUS[7:2];
  assign hit_imsk = wb_adr_i[7:2] == rspl_pkg::OFF_INT_MASK[7:2];

  // status bits, unused positions read as zero
  logic [1:0] led_pol; // indicator polarity, 1 = active low
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[rspl_pkg::STAT_CFG_BIT] = cfg_use;
    stat_word[rspl_pkg::STAT_DRV_LSB +: 2] = phy_drive_current_setting;
    stat_word[rspl_pkg::STAT_POL_BIT] = pol_use;
    stat_word[rspl_pkg::STAT_LEDPOL_LSB +: 2] = led_pol;
    stat_word[rspl_pkg::STAT_OC_LSB +: NPORTS] = oc_now;
    stat_word[rspl_pkg::STAT_DONE_BIT] = rst_done;
  end

  // unmapped addresses read zero and ignore writes
  assign next_rdata = hit_ctrl ? ctrl :
                      hit_stat ? stat_word :
                      hit_ist ? int_st :
                      hit_imsk ? int_mask : 32'h0000_0000;

  // answer one cycle after the request; drop after one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // control and mask writes land on the acknowledging edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl <= rspl_pkg::CTRL_RESET;
      int_mask <= rspl_pkg::INT_RESET;
    end else if (ce && wr_now) begin
      if (hit_ctrl) begin
        ctrl <= rspl_pkg::CTRL_MASK & rspl_merge(ctrl, wb_dat_i, wb_sel_i);
      end
      if (hit_imsk) begin
        int_mask <= rspl_merge(int_mask, wb_dat_i, wb_sel_i)
                    & {{(32-NPORTS){1'b0}}, {NPORTS{1'b1}}};
      end
    end
  end

  // ==========================================================
  // over-current events and interrupt
  // ==========================================================
  logic [NPORTS-1:0] oc_prev; // level seen last cycle
  logic [31:0] oc_event; // rising over-current per port
  logic [31:0] int_clr; // write-one-to-clear mask
  logic [31:0] next_int_st; // next sticky bits

  assign oc_event = {{(32-NPORTS){1'b0}}, oc_now & ~oc_prev};
  assign int_clr = (wr_now && hit_ist) ? 
                   rspl_merge(32'h0000_0000, wb_dat_i, wb_sel_i)
                   : 32'h0000_0000;
  // a new event in the clearing cycle survives the clear
  assign next_int_st = (int_st & ~int_clr) | oc_event;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oc_prev <= '0;
      int_st <= rspl_pkg::INT_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      oc_prev <= oc_now;
      int_st <= next_int_st;
      irq <= |(next_int_st & int_mask);
    end
  end

  // ==========================================================
  // drive setting and indicators
  // ==========================================================
  logic led_en; // indicator support enabled
  logic [1:0] led_on; // indicator requested on
  logic [1:0] next_drive; // drive setting to present
  logic [1:0] next_led; // indicator pin levels

  assign led_en = ctrl[rspl_pkg::CTRL_LED_EN_BIT];
  assign led_on = ctrl[rspl_pkg::CTRL_LED_ON_LSB +: 2] & {2{led_en}};
  // strap value used directly as drive setting when config select is honoured, default otherwise
  assign next_drive = cfg_use ? drv_use : rspl_pkg::DRV_DEFAULT;
  // bit 1 port 2, bit 0 port 1
  // active low when strap not honoured
  assign led_pol = cfg_use ? drv_use : 2'h3;
  // off pins rest at the inactive level of their polarity
  assign next_led = led_pol ^ led_on;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phy_drive_current_setting <= rspl_pkg::DRV_DEFAULT;
      enhanced_port_indicator <= 2'h3;
    end else if (ce) begin
      phy_drive_current_setting <= next_drive;
      enhanced_port_indicator <= next_led;
    end
  end

  // ==========================================================
  // port power enables
  // ==========================================================
  logic [NPORTS-1:0] pwr_on; // power wanted and safe
  logic [NPORTS-1:0] pwr_q; // registered pin level
  // power is cut while the port reports over-current
  assign pwr_on = ctrl[rspl_pkg::CTRL_PWR_LSB +: NPORTS] & ~oc_now;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pwr_q <= '0;
    end else if (ce) begin
      pwr_q <= pol_use ? pwr_on : ~pwr_on;
    end
  end

  // the only path that is not a plain flop: under reset no clock
  // edge can be relied on, so the off level must follow the pin
  // reset path uses live strap
  assign port_power_enable_out = rst_done ? pwr_q : {NPORTS{~pol_live}};

  // ==========================================================
  // checks
  // ==========================================================
  chk_power_in_reset: assert property (
    @(posedge clk_sys) !nrst |-> port_power_enable_out == {NPORTS{~pol_live}})
    else $error("power enable active during reset");

  chk_polarity_held: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rst_done |=> $stable(pol_q) && rst_done)
    else $error("latched polarity changed after release");

  chk_power_level: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rst_done && ce) |=> port_power_enable_out ==
      (pol_q ? $past(pwr_on) : ~$past(pwr_on)))
    else $error("power enable level does not match polarity");

  chk_no_pin_high: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    HAS_POL_STRAP || (pol_use && pol_live))
    else $error("polarity not active high without strap pin");

  chk_drive_setting: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rst_done && ce) |=> phy_drive_current_setting ==
      (cfg_q ? drv_q : rspl_pkg::DRV_DEFAULT))
    else $error("drive setting differs from sampled strap");

  chk_led_strap_pol: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rst_done && ce && cfg_q && led_en && ctrl[rspl_pkg::CTRL_LED_ON_LSB+1])
    |=> enhanced_port_indicator[1] == ~drv_q[1])
    else $error("port 2 indicator level ignores strap polarity");

  chk_led_active_low: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rst_done && ce && !cfg_q && led_en && ctrl[rspl_pkg::CTRL_LED_ON_LSB])
    |=> enhanced_port_indicator[0] == 1'b0)
    else $error("port 1 indicator not driven low when on");

  chk_cfg_held: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rst_done |=> $stable(cfg_q) && $stable(drv_q))
    else $error("latched straps changed after release");

  chk_oc_sync: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && !overcurrent_sense_in_n[0])[*3] |-> oc_now[0])
    else $error("over-current not seen after two flops");

  chk_oc_power_cut: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rst_done && ce && oc_now[0]) |=>
      port_power_enable_out[0] == ~pol_q)
    else $error("power stays on during over-current");

  chk_irq_level: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ce |=> irq == |(int_st & $past(int_mask)))
    else $error("interrupt output does not follow masked status");

  chk_bus_answer: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && req && !wb_ack_o) |=> wb_ack_o ##1 (!wb_ack_o || !ce))
    else $error("bus answer not one cycle after request");

  chk_ack_idle: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && !req) |=> !wb_ack_o)
    else $error("bus answer without a request");

  // a rising over-current must land even in a clearing cycle
  chk_event_wins: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ce && oc_now[0] && !oc_prev[0]) |=> int_st[0])
    else $error("over-current event not recorded");

  // only a one written to the bit may drop it
  chk_int_sticky: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (int_st[0] && !(wr_now && hit_ist && wb_sel_i[0] && wb_dat_i[0]))
    |=> int_st[0])
    else $error("event bit dropped without a clear");

endmodule : rspl_top

// ### rspl_partner.sv
// far-side model: strap resistors and over-current monitors
`timescale 1ns/1ps
module rspl_partner (
  input wire logic clk_sys,
  input wire logic cfg_set,
  input wire logic [1:0] drv_set,
  input wire logic pol_set,
  input wire logic [1:0] fault,
  input wire logic [3:0] lag,
  output logic cfg_select_strap,
  output logic [1:0] drive_level_strap,
  output logic port_power_polarity_strap,
  output logic [1:0] overcurrent_sense_in_n
);
  // ========================================================
  // strap resistors
  // ========================================================
  logic [3:0] age [2]; // cycles each fault has persisted
  // resistors give a static level, no clock involved
  assign cfg_select_strap = cfg_set;
  assign drive_level_strap = drv_set;
  assign port_power_polarity_strap = pol_set;
  // ========================================================
  // current monitors
  // ========================================================
  // age saturates so a long fault never wraps back to clear
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (!fault[i]) begin
        age[i] <= 4'h0;
      end else if (age[i] != 4'hF) begin
        age[i] <= age[i] + 4'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      overcurrent_sense_in_n[i] = !(fault[i] && (age[i] >= lag));
    end
  end
endmodule : rspl_partner

// ### test_reset_strap_polarity_latch.sv
// self-checking bench for the strap capture and polarity block
`timescale 1ns/1ps
`define CHK(nm, e, s) tests_run++; \
  if ((s) !== (e)) begin \
    err_total++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); \
  end
module test_reset_strap_polarity_latch;
  typedef struct {string nm; logic [31:0] v;} rspl_note_s;
  rspl_note_s notes[$]; // expected results, oldest first
  rspl_note_s cur; // note under comparison
  int err_total = 0;
  int tests_run = 0;
  logic clk_sys, nrst, ce, probe; // probe asks for a pin check
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, lfsr, pins;
  logic wb_ack_o, irq, cfg_s, pol_s, cfg_set, pol_set, p;
  logic [1:0] drv_s, drv_set, fault, oc_n, pwr, fix_pwr, ind, drv, on;
  logic [3:0] lag;
  // ========================================================
  // design, fixed-polarity variant and far side
  // ========================================================
  rspl_top uut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_select_strap(cfg_s),
    .drive_level_strap(drv_s), .port_power_polarity_strap(pol_s),
    .overcurrent_sense_in_n(oc_n), .port_power_enable_out(pwr),
    .enhanced_port_indicator(ind), .phy_drive_current_setting(drv),
    .irq(irq));
  // shares the bus so its power request follows the main one
  rspl_top #(.HAS_POL_STRAP(1'b0)) uut_fixed (.clk_sys(clk_sys),
    .nrst(nrst), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .cfg_select_strap(cfg_s), .drive_level_strap(drv_s),
    .port_power_polarity_strap(pol_s), .overcurrent_sense_in_n(oc_n),
    .port_power_enable_out(fix_pwr), .enhanced_port_indicator(),
    .phy_drive_current_setting(), .irq());
  rspl_partner far (.clk_sys(clk_sys), .cfg_set(cfg_set),
    .drv_set(drv_set), .pol_set(pol_set), .fault(fault), .lag(lag),
    .cfg_select_strap(cfg_s), .drive_level_strap(drv_s),
    .port_power_polarity_strap(pol_s), .overcurrent_sense_in_n(oc_n));
  assign pins = {23'h0, fix_pwr, pwr, ind, drv, irq};
  // ========================================================
  // helpers
  // ========================================================
  function automatic logic [31:0] rspl_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rspl_lfsr
  function automatic logic [31:0] pv(input logic [1:0] f, w, i, d,
                                     input logic q);
    return {23'h0, f, w, i, d, q};
  endfunction : pv
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // one classic cycle, released only after ack is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    // ack is looked at on the rising edge that ends its cycle
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input string nm);
    notes.push_back('{nm, v});
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic chk_pins(input string nm, input logic [31:0] v);
    notes.push_back('{nm, v});
    repeat (2) @(posedge clk_sys);
    probe <= 1'b1;
    @(posedge clk_sys);
    probe <= 1'b0;
  endtask : chk_pins
  task automatic do_reset(input logic c, input logic [1:0] d,
                          input logic q);
    nrst <= 1'b0;
    cfg_set <= c;
    drv_set <= d;
    pol_set <= q;
    repeat (25) @(posedge clk_sys);
  endtask : do_reset
  // straps stay steady across the release edge
  task automatic release_rst();
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : release_rst
  // ========================================================
  // clock and result watcher
  // ========================================================
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // falling edge sampling keeps clear of launch-edge races
  always @(negedge clk_sys) begin
    if ((wb_ack_o === 1'b1 && wb_we_i == 1'b0) || probe) begin
      if (notes.size() == 0) begin
        err_total++;
      end else begin
        cur = notes.pop_front();
        `CHK(cur.nm, cur.v, (probe ? pins : wb_dat_o))
      end
    end
  end
  // ========================================================
  // scenarios
  // ========================================================
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, probe, cfg_set} = 6'h0;
    {wb_adr_i, wb_dat_i, drv_set, fault} = 44'h0;
    {ce, pol_set, wb_sel_i, lag, lfsr} = {6'h3F, 4'h0, 32'h8BE4};
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      p = i[0];
      lfsr = rspl_lfsr(lfsr);
      on = lfsr[1:0];
      do_reset(1'b1, i[1:0], p);
      chk_pins("rst_pwr",
               pv(2'b00, {2{~p}}, 2'b11, 2'b00, 1'b0));
      pol_set <= ~p;
      chk_pins("rst_live", pv(2'b00, {2{p}}, 2'b11, 2'b00, 1'b0));
      pol_set <= p;
      release_rst();
      pol_set <= ~p;
      drv_set <= ~i[1:0];
      chk_pins("latch",
               pv(2'b00, {2{~p}}, i[1:0], i[1:0], 1'b0));
      bus(1'b1, rspl_pkg::OFF_CTRL, {14'h0, on, 6'h0, 2'b11, 7'h0, 1'b1});
      chk_pins("drive",
               pv(2'b11, {2{p}}, i[1:0] ^ on, i[1:0], 1'b0));
    end
    do_reset(1'b0, 2'b11, 1'b1);
    release_rst();
    chk_pins("cfg_off", pv(2'b00, 2'b00, 2'b11, 2'b00, 1'b0));
    bus(1'b1, rspl_pkg::OFF_CTRL, 32'h0003_0301);
    chk_pins("led_low", pv(2'b11, 2'b11, 2'b00, 2'b00, 1'b0));
    bus(1'b1, rspl_pkg::OFF_INT_MASK, 32'h1);
    fault <= 2'b01;
    repeat (6) @(posedge clk_sys);
    chk_pins("oc_cut", pv(2'b10, 2'b10, 2'b00, 2'b00, 1'b1));
    rd(rspl_pkg::OFF_INT_STATUS, 32'h1, "int_st");
    rd(rspl_pkg::OFF_STATUS, 32'h0000_8138, "status");
    lag <= 4'hA;
    fault <= 2'b11;
    repeat (16) @(posedge clk_sys);
    rd(rspl_pkg::OFF_INT_STATUS, 32'h3, "int_slow");
    fault <= 2'b00;
    repeat (6) @(posedge clk_sys);
    bus(1'b1, rspl_pkg::OFF_INT_STATUS, 32'h1);
    chk_pins("clr0", pv(2'b11, 2'b11, 2'b00, 2'b00, 1'b0));
    rd(rspl_pkg::OFF_INT_STATUS, 32'h2, "int_left");
    bus(1'b1, rspl_pkg::OFF_INT_MASK, 32'h2);
    chk_pins("mask1", pv(2'b11, 2'b11, 2'b00, 2'b00, 1'b1));
    bus(1'b1, rspl_pkg::OFF_INT_STATUS, 32'h2);
    chk_pins("clr1", pv(2'b11, 2'b11, 2'b00, 2'b00, 1'b0));
    // clock enable low: a new fault must not reach any output
    ce <= 1'b0;
    lag <= 4'h0;
    fault <= 2'b10;
    chk_pins("frozen", pv(2'b11, 2'b11, 2'b00, 2'b00, 1'b0));
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_pins("thawed", pv(2'b01, 2'b01, 2'b00, 2'b00, 1'b1));
    fault <= 2'b00;
    bus(1'b1, rspl_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rd(rspl_pkg::OFF_STATUS, 32'h0000_8038, "st_ro");
    lfsr = rspl_lfsr(lfsr);
    bus(1'b1, rspl_pkg::OFF_CTRL, lfsr);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0, "unmapped");
    rd(rspl_pkg::OFF_CTRL, lfsr & rspl_pkg::CTRL_MASK, "ctrl_rb");
    repeat (2) @(posedge clk_sys);
    if (notes.size() != 0) begin
      err_total++;
    end
    wrap_up();
  end
endmodule : test_reset_strap_polarity_latch
